/* rtl/eid_debounce.sv */
module eid_debounce
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic en_i,
	input wire logic [eid_pkg::PERIOD_W-1:0] period_i,
	input wire logic level_i,
	output logic filtered_o
);
	logic [eid_pkg::PERIOD_W-1:0] cnt;
	logic [eid_pkg::PERIOD_W-1:0] next_cnt;
	logic next_out;
	logic [eid_pkg::PERIOD_W:0] cnt_plus;

	always_comb
	begin
		next_cnt = cnt;
		next_out = filtered_o;
		cnt_plus = {1'b0, cnt} + {{eid_pkg::PERIOD_W{1'b0}}, 1'b1};
		if (!en_i)
		begin
			// Bypass: no stability
			next_out = level_i;
			next_cnt = '0;
		end
		else if (level_i == filtered_o)
		begin
			next_cnt = '0;
		end
		else if (tick_i)
		begin
			// Counts only slow-clock periods; either direction
			if (cnt_plus >= {1'b0, period_i})
			begin
				next_out = level_i;
				next_cnt = '0;
			end
			else
			begin
				next_cnt = cnt_plus[eid_pkg::PERIOD_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt <= '0;
			filtered_o <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			filtered_o <= next_out;
		end
	end

	a_change_needs_count: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(en_i) && $changed(filtered_o) |-> $past(cnt_plus) >= {1'b0, $past(period_i)})
		else $error("filter output moved before the stable count");
	a_both_directions: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(filtered_o) |-> filtered_o == $past(level_i))
		else $error("filter output moved away from the input level");
	a_slow_tick_only: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(en_i) && $changed(filtered_o) |-> $past(tick_i))
		else $error("filter output moved without a slow clock edge");
	a_bypass_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		!en_i |=> filtered_o == $past(level_i))
		else $error("disabled filter did not pass the input");
endmodule

/* rtl/eid_pkg.sv */
package eid_pkg;
	// Count of conditioned event inputs
	localparam int NUM_INPUTS = 4;
	localparam int PERIOD_W = 16;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_PERIOD = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_MASK = 5'h0c;
	localparam logic [ADDR_W-1:0] OFF_LEVEL = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_APPLIED = 5'h14;

	// Control register field positions
	localparam int CTRL_DEB_EN_LSB = 0;
	localparam int CTRL_EDGE_LSB = 8;
	localparam int CTRL_POL_LSB = 16;

	// Applied-settings readback field positions
	localparam int APPL_PERIOD_LSB = 0;
	localparam int APPL_DEB_EN_LSB = 16;

	// Values after reset
	localparam logic [NUM_INPUTS-1:0] DEB_EN_RST = 4'h0;
	localparam logic [NUM_INPUTS-1:0] EDGE_RST = 4'h0;
	localparam logic [NUM_INPUTS-1:0] POL_RST = 4'h0;
	localparam logic [NUM_INPUTS-1:0] MASK_RST = 4'h0;
	localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0001;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
endpackage

/* rtl/eid_sync2.sv */
module eid_sync2
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [eid_pkg::NUM_INPUTS:0] d_i,
	output logic [eid_pkg::NUM_INPUTS:0] q_o
);
	logic [eid_pkg::NUM_INPUTS:0] meta;
	logic [eid_pkg::NUM_INPUTS:0] next_meta;
	logic [eid_pkg::NUM_INPUTS:0] next_q;

	always_comb
	begin
		next_meta = d_i;
		next_q = meta;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta <= '0;
			q_o <= '0;
		end
		else
		begin
			meta <= next_meta;
			q_o <= next_q;
		end
	end
endmodule

/* rtl/eid_top.sv */
// Decided for this implementation: the Avalon-MM register port and the address map.
module eid_top
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_clk_i,
	input wire logic [eid_pkg::NUM_INPUTS-1:0] external_event_input_i,
	input wire logic [eid_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [eid_pkg::DATA_W-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [eid_pkg::DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	output logic [eid_pkg::NUM_INPUTS-1:0] event_level_o
);
	localparam int N = eid_pkg::NUM_INPUTS;
	localparam int PW = eid_pkg::PERIOD_W;

	// Applies byte enables to a stored word
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		end
		return r;
	endfunction

	// Synchronized pins
	logic [N:0] sync_q;
	logic slow_prev;
	logic next_slow_prev;
	logic tick;
	logic [N-1:0] sync_in;

	// Software settings
	logic [N-1:0] deb_en_sw;
	logic [N-1:0] edge_mode;
	logic [N-1:0] polarity;
	logic [N-1:0] mask;
	logic [PW-1:0] period_sw;
	logic [N-1:0] next_deb_en_sw;
	logic [N-1:0] next_edge_mode;
	logic [N-1:0] next_polarity;
	logic [N-1:0] next_mask;
	logic [PW-1:0] next_period_sw;

	// Slow-domain staging of period and enable
	logic [N-1:0] deb_en_stage;
	logic [N-1:0] deb_en_act;
	logic [PW-1:0] period_stage;
	logic [PW-1:0] period_act;
	logic [N-1:0] next_deb_en_stage;
	logic [N-1:0] next_deb_en_act;
	logic [PW-1:0] next_period_stage;
	logic [PW-1:0] next_period_act;

	// Detection
	logic [N-1:0] deb_level;
	logic [N-1:0] pol_level;
	logic [N-1:0] pol_prev;
	logic [N-1:0] status;
	logic [N-1:0] next_pol_prev;
	logic [N-1:0] next_status;
	logic [N-1:0] ev_set;
	logic [N-1:0] st_clr;
	logic next_irq;

	// Bus
	logic req;
	logic commit;
	logic [31:0] ctrl_word;
	logic [31:0] wr_word;
	logic [31:0] next_readdata;
	logic next_wait;

	eid_sync2 u_sync
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({slow_clk_i, external_event_input_i}),
		.q_o(sync_q)
	);

	assign sync_in = sync_q[N-1:0];
	assign tick = sync_q[N] && !slow_prev;

	always_comb
	begin
		next_slow_prev = sync_q[N];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			slow_prev <= 1'b0;
		else
			slow_prev <= next_slow_prev;
	end

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_filter
			eid_debounce u_deb
			(
				.clk_i(clk_i),
				.rst_i(rst_i),
				.tick_i(tick),
				.en_i(deb_en_act[gi]),
				.period_i(period_act),
				.level_i(sync_in[gi]),
				.filtered_o(deb_level[gi])
			);
		end
	endgenerate

	// Polarity in the system clock domain, no slow-clock wait
	assign pol_level = deb_level ^ polarity;

	// Bus request is answered one cycle after it is seen
	assign req = avs_read_i || avs_write_i;
	assign commit = avs_write_i && !avs_waitrequest_o;
	assign wr_word = avs_writedata_i;

	always_comb
	begin
		ctrl_word = eid_pkg::READ_ZERO;
		ctrl_word[eid_pkg::CTRL_DEB_EN_LSB +: N] = deb_en_sw;
		ctrl_word[eid_pkg::CTRL_EDGE_LSB +: N] = edge_mode;
		ctrl_word[eid_pkg::CTRL_POL_LSB +: N] = polarity;
	end

	always_comb
	begin
		logic [31:0] merged;
		merged = eid_pkg::READ_ZERO;
		next_deb_en_sw = deb_en_sw;
		next_edge_mode = edge_mode;
		next_polarity = polarity;
		next_mask = mask;
		next_period_sw = period_sw;
		st_clr = '0;
		if (commit)
		begin
			if (avs_address_i == eid_pkg::OFF_CTRL)
			begin
				merged = be_merge(ctrl_word, wr_word, avs_byteenable_i);
				next_deb_en_sw = merged[eid_pkg::CTRL_DEB_EN_LSB +: N];
				next_edge_mode = merged[eid_pkg::CTRL_EDGE_LSB +: N];
				next_polarity = merged[eid_pkg::CTRL_POL_LSB +: N];
			end
			else if (avs_address_i == eid_pkg::OFF_PERIOD)
			begin
				merged = be_merge({16'h0000, period_sw}, wr_word, avs_byteenable_i);
				next_period_sw = merged[PW-1:0];
			end
			else if (avs_address_i == eid_pkg::OFF_STATUS)
			begin
				merged = be_merge(eid_pkg::READ_ZERO, wr_word, avs_byteenable_i);
				st_clr = merged[N-1:0];
			end
			else if (avs_address_i == eid_pkg::OFF_MASK)
			begin
				merged = be_merge({28'h0000000, mask}, wr_word, avs_byteenable_i);
				next_mask = merged[N-1:0];
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			deb_en_sw <= eid_pkg::DEB_EN_RST;
			edge_mode <= eid_pkg::EDGE_RST;
			polarity <= eid_pkg::POL_RST;
			mask <= eid_pkg::MASK_RST;
			period_sw <= eid_pkg::PERIOD_RST;
		end
		else
		begin
			deb_en_sw <= next_deb_en_sw;
			edge_mode <= next_edge_mode;
			polarity <= next_polarity;
			mask <= next_mask;
			period_sw <= next_period_sw;
		end
	end

	// Period and enable settings move only on slow edges, through two stages, so a write lands on the second slow edge after it, one to two slow periods later
	always_comb
	begin
		next_deb_en_stage = deb_en_stage;
		next_deb_en_act = deb_en_act;
		next_period_stage = period_stage;
		next_period_act = period_act;
		if (tick)
		begin
			next_deb_en_stage = deb_en_sw;
			next_period_stage = period_sw;
			next_deb_en_act = deb_en_stage;
			next_period_act = period_stage;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			deb_en_stage <= eid_pkg::DEB_EN_RST;
			deb_en_act <= eid_pkg::DEB_EN_RST;
			period_stage <= eid_pkg::PERIOD_RST;
			period_act <= eid_pkg::PERIOD_RST;
		end
		else
		begin
			deb_en_stage <= next_deb_en_stage;
			deb_en_act <= next_deb_en_act;
			period_stage <= next_period_stage;
			period_act <= next_period_act;
		end
	end

	// Edge mode flags a rise, level mode flags while active; a set beats a clear
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			if (edge_mode[i])
				ev_set[i] = pol_level[i] && !pol_prev[i];
			else
				ev_set[i] = pol_level[i];
		end
		next_pol_prev = pol_level;
		next_status = (status & ~st_clr) | ev_set;
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pol_prev <= '0;
			status <= '0;
			irq_o <= 1'b0;
			event_level_o <= '0;
		end
		else
		begin
			pol_prev <= next_pol_prev;
			status <= next_status;
			irq_o <= next_irq;
			event_level_o <= pol_level;
		end
	end

	// Read data and waitrequest
	always_comb
	begin
		next_wait = !(req && avs_waitrequest_o);
		next_readdata = eid_pkg::READ_ZERO;
		if (avs_read_i && avs_waitrequest_o)
		begin
			if (avs_address_i == eid_pkg::OFF_CTRL)
				next_readdata = ctrl_word;
			else if (avs_address_i == eid_pkg::OFF_PERIOD)
				next_readdata = {16'h0000, period_sw};
			else if (avs_address_i == eid_pkg::OFF_STATUS)
				next_readdata = {28'h0000000, status};
			else if (avs_address_i == eid_pkg::OFF_MASK)
				next_readdata = {28'h0000000, mask};
			else if (avs_address_i == eid_pkg::OFF_LEVEL)
				next_readdata = {28'h0000000, pol_level};
			else if (avs_address_i == eid_pkg::OFF_APPLIED)
			begin
				next_readdata[eid_pkg::APPL_PERIOD_LSB +: PW] = period_act;
				next_readdata[eid_pkg::APPL_DEB_EN_LSB +: N] = deb_en_act;
			end
		end
		else if (!avs_waitrequest_o)
		begin
			next_readdata = avs_readdata_o;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= eid_pkg::READ_ZERO;
		end
		else
		begin
			avs_waitrequest_o <= next_wait;
			avs_readdata_o <= next_readdata;
		end
	end

	a_period_on_tick: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(period_act) || $changed(deb_en_act) |-> $past(tick))
		else $error("applied setting changed off a slow edge");
	a_period_two_stage: assert property (@(posedge clk_i) disable iff (rst_i)
		tick |=> period_act == $past(period_stage) && deb_en_act == $past(deb_en_stage))
		else $error("applied setting skipped the staging step");
	a_polarity_now: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(polarity) && $stable(deb_level) |=> event_level_o == ($past(deb_level) ^ $past(polarity)))
		else $error("polarity change was not applied at once");
	a_edge_sets: assert property (@(posedge clk_i) disable iff (rst_i)
		edge_mode[2] && pol_level[2] && !pol_prev[2] |=> status[2])
		else $error("edge on input two did not set status");
	a_edge_no_level: assert property (@(posedge clk_i) disable iff (rst_i)
		edge_mode[2] && !status[2] && pol_prev[2] && pol_level[2] |=> !status[2])
		else $error("edge mode flagged a steady level");
	a_level_sets: assert property (@(posedge clk_i) disable iff (rst_i)
		!edge_mode[1] && pol_level[1] |=> status[1])
		else $error("level mode did not flag an active input");
	a_irq_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == |(status & mask))
		else $error("interrupt does not follow masked status");
	a_bus_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus answer not one cycle after request");
endmodule

/* tb/eid_partner.sv */
module eid_partner
(
	input wire logic clk_i,
	input wire logic [eid_pkg::NUM_INPUTS-1:0] level_i,
	input wire logic [eid_pkg::NUM_INPUTS-1:0] glitch_i,
	output logic [eid_pkg::NUM_INPUTS-1:0] pins_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Contact bounce shows as a short flip of the steady level; idle level is low
	always @(posedge clk_i)
	begin
		pins_o <= level_i ^ glitch_i;
	end
endmodule

/* tb/eid_top_test.sv */
module eid_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	// Slow clock scaled down to keep the run short
	localparam int SLOW_HALF = 20;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic slow_clk = 1'b0;
	logic [eid_pkg::NUM_INPUTS-1:0] lvl = '0;
	logic [eid_pkg::NUM_INPUTS-1:0] glt = '0;
	logic [eid_pkg::NUM_INPUTS-1:0] pins;
	logic [eid_pkg::ADDR_W-1:0] addr = '0;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [eid_pkg::DATA_W-1:0] wdata = '0;
	logic [eid_pkg::DATA_W-1:0] rdata;
	logic [eid_pkg::DATA_W-1:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic irq_o;
	logic [eid_pkg::NUM_INPUTS-1:0] event_level_o;
	int n_fail = 0;
	int n_tests = 0;

	eid_partner eid_partner_i (.clk_i(clk_i), .level_i(lvl), .glitch_i(glt), .pins_o(pins));
	eid_top eid_top_i (.clk_i(clk_i), .rst_i(rst_i), .slow_clk_i(slow_clk), .external_event_input_i(pins),
		.avs_address_i(addr), .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
		.avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.irq_o(irq_o), .event_level_o(event_level_o));

	initial
	begin
		forever #5 clk_i = ~clk_i;
	end

	always
	begin
		repeat (SLOW_HALF) @(posedge clk_i);
		slow_clk <= ~slow_clk;
	end

	task automatic wrap_up;
		$display("tests=%0d fails=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Holds the request until the rising edge at which waitrequest is sampled low; read data taken there
	task automatic wait_ack;
		@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0)
			@(posedge clk_i);
		rdata = avs_readdata_o;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		wait_ack();
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		addr <= a;
		rd_en <= 1'b1;
		wait_ack();
		rd_en <= 1'b0;
		check(rdata, exp);
	endtask

	task automatic t_reset;
		rd(eid_pkg::OFF_CTRL, 32'h0000_0000);
		rd(eid_pkg::OFF_PERIOD, 32'h0000_0001);
		rd(eid_pkg::OFF_APPLIED, 32'h0000_0001);
		rd(5'h1c, eid_pkg::READ_ZERO);
		wr(eid_pkg::OFF_MASK, 32'h0000_000f);
		rd(eid_pkg::OFF_MASK, 32'h0000_000f);
	endtask

	task automatic t_bypass;
		lvl[0] <= 1'b1;
		cyc(8);
		check(32'(event_level_o), 32'h1);
		check(32'(irq_o), 32'h1);
		wr(eid_pkg::OFF_STATUS, 32'h1);
		rd(eid_pkg::OFF_STATUS, 32'h1);
		lvl[0] <= 1'b0;
		cyc(8);
		wr(eid_pkg::OFF_STATUS, 32'hf);
		cyc(2);
		check(32'(irq_o), 32'h0);
	endtask

	task automatic t_polarity;
		wr(eid_pkg::OFF_CTRL, 32'h0002_0000);
		cyc(2);
		check(32'(event_level_o), 32'h2);
		rd(eid_pkg::OFF_LEVEL, 32'h2);
		wr(eid_pkg::OFF_MASK, 32'h0);
		cyc(2);
		check(32'(irq_o), 32'h0);
		wr(eid_pkg::OFF_MASK, 32'hf);
		wr(eid_pkg::OFF_CTRL, 32'h0);
		wr(eid_pkg::OFF_STATUS, 32'hf);
	endtask

	task automatic t_edge;
		wr(eid_pkg::OFF_CTRL, 32'h0000_0400);
		lvl[2] <= 1'b1;
		cyc(8);
		rd(eid_pkg::OFF_STATUS, 32'h4);
		wr(eid_pkg::OFF_STATUS, 32'h4);
		cyc(4);
		rd(eid_pkg::OFF_STATUS, 32'h0);
		lvl[2] <= 1'b0;
		cyc(8);
		rd(eid_pkg::OFF_STATUS, 32'h0);
		wr(eid_pkg::OFF_CTRL, 32'h0);
	endtask

	task automatic t_debounce;
		wr(eid_pkg::OFF_PERIOD, 32'h3);
		wr(eid_pkg::OFF_CTRL, 32'h8);
		rd(eid_pkg::OFF_APPLIED, 32'h0000_0001);
		cyc(90);
		rd(eid_pkg::OFF_APPLIED, 32'h0008_0003);
		glt[3] <= 1'b1;
		cyc(20);
		glt[3] <= 1'b0;
		cyc(150);
		check(32'(event_level_o), 32'h0);
		lvl[3] <= 1'b1;
		cyc(75);
		check(32'(event_level_o), 32'h0);
		cyc(65);
		check(32'(event_level_o), 32'h8);
		lvl[3] <= 1'b0;
		cyc(75);
		check(32'(event_level_o), 32'h8);
		cyc(65);
		check(32'(event_level_o), 32'h0);
		wr(eid_pkg::OFF_STATUS, 32'hf);
		wr(eid_pkg::OFF_CTRL, 32'h0);
	endtask

	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_bypass();
		t_polarity();
		t_edge();
		t_debounce();
		wrap_up();
	end

	initial
	begin
		repeat (4000) @(posedge clk_i);
		n_fail++;
		wrap_up();
	end
endmodule
